// file: rtl/sdcf_host.sv
/*
 Host-side command framer for the native memory-card bus: makes the card
 clock, shifts commands out on the two-way command line, collects short or
 long responses and checks them. Assumes the pins pass through tristate
 buffers outside this module and one 250 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
module sdcf_host (
   input  wire logic                 mclk,
   input  wire logic                 resetn,
   input  wire logic                 cmd_valid,
   output logic                      cmd_ready,
   input  wire logic [5:0]           cmd_index,
   input  wire logic [31:0]          cmd_arg,
   input  wire sdcf_pkg::sdcf_kind_t cmd_kind,
   input  wire logic [9:0]           clk_half,
   input  wire logic                 hs_mode,
   input  wire logic                 id_mode,
   input  wire logic [15:0]          rsp_timeout,
   output logic                      rsp_valid,
   input  wire logic                 rsp_ready,
   output logic [5:0]                rsp_index,
   output logic [31:0]               rsp_arg,
   output logic [135:0]              rsp_frame,
   output logic                      rsp_timed_out,
   output logic                      rsp_crc_err,
   output logic                      rsp_frm_err,
   output logic                      sd_clk,
   input  wire logic                 sd_cmd_in,
   output logic                      sd_cmd_out,
   output logic                      sd_cmd_oe,
   output logic [7:0]                sd_dat_out,
   output logic [7:0]                sd_dat_oe
);

   typedef struct packed {
      sdcf_pkg::sdcf_state_t st;
      sdcf_pkg::sdcf_kind_t  kind;
      logic                  cmd_ready;
      logic                  clk;
      logic [9:0]            div;
      logic [7:0]            cnt;
      logic [15:0]           wcnt;
      logic [47:0]           sh;
      logic [135:0]          rx;
      logic                  tmo;
      logic                  sync1;
      logic                  sync2;
      logic                  cmd_out;
      logic                  cmd_oe;
      logic [7:0]            dat_out;
      logic [7:0]            dat_oe;
      sdcf_pkg::sdcf_rsp_t   rsp;
   } sdcf_host_t;

   sdcf_host_t s_reg;
   sdcf_host_t s_next;
   logic       rise;
   logic       fall;
   logic       run;
   logic [9:0] half;

   sdcf_if push_if ();
   sdcf_if pop_if ();

   sdcf_buf u_buf (
      .mclk   (mclk),
      .resetn (resetn),
      .wr     (push_if),
      .rd     (pop_if)
   );

   assign push_if.valid = (s_reg.st == sdcf_pkg::ST_PUSH);
   assign push_if.data  = s_reg.rsp;
   assign pop_if.ready  = rsp_ready;

   assign cmd_ready     = s_reg.cmd_ready;
   assign sd_clk        = s_reg.clk;
   assign sd_cmd_out    = s_reg.cmd_out;
   assign sd_cmd_oe     = s_reg.cmd_oe;
   assign sd_dat_out    = s_reg.dat_out;
   assign sd_dat_oe     = s_reg.dat_oe;
   assign rsp_valid     = pop_if.valid;
   assign rsp_index     = pop_if.data.index;
   assign rsp_arg       = pop_if.data.arg;
   assign rsp_frame     = pop_if.data.frame;
   assign rsp_timed_out = pop_if.data.timeout;
   assign rsp_crc_err   = pop_if.data.crc_err;
   assign rsp_frm_err   = pop_if.data.frm_err;

   // A too small divider setting is raised to the floor of the chosen mode,
   // so software cannot overclock the card by mistake.
   always_comb
   begin
      logic [9:0] floor_half;
      floor_half = id_mode ? sdcf_pkg::HALF_ID :
                   hs_mode ? sdcf_pkg::HALF_HS : sdcf_pkg::HALF_DS;
      half = (clk_half > floor_half) ? clk_half : floor_half;
   end

   // The clock stops only while low, so the idle level is always low.
   assign run = (s_reg.st != sdcf_pkg::ST_IDLE) &&
                (s_reg.st != sdcf_pkg::ST_PUSH);

   always_comb
   begin
      logic [7:0] len;
      logic       short_rsp;
      s_next = s_reg;
      len = (s_reg.kind == sdcf_pkg::KIND_LONG) ? sdcf_pkg::LONG_BITS
                                                : sdcf_pkg::CMD_BITS;
      short_rsp = (s_reg.kind == sdcf_pkg::KIND_SHORT);
      rise = 1'b0;
      fall = 1'b0;
      s_next.sync1 = sd_cmd_in;
      s_next.sync2 = s_reg.sync1;
      if (!run)
      begin
         s_next.div = '0;
         s_next.clk = 1'b0;
      end
      else if (s_reg.div >= half - 10'h001)
      begin
         s_next.div = '0;
         s_next.clk = !s_reg.clk;
         rise = !s_reg.clk;
         fall = s_reg.clk;
      end
      else
         s_next.div = s_reg.div + 10'h001;

      case (s_reg.st)
         sdcf_pkg::ST_IDLE:
         begin
            if (cmd_valid && s_reg.cmd_ready)
            begin
               s_next.kind = cmd_kind;
               s_next.cnt = '0;
               s_next.tmo = 1'b0;
               s_next.rx = '0;
               s_next.cmd_oe = 1'b1;
               if (cmd_kind == sdcf_pkg::KIND_INIT)
               begin
                  s_next.cmd_out = sdcf_pkg::LINE_IDLE;
                  s_next.dat_oe = '1;
                  s_next.st = sdcf_pkg::ST_INIT;
               end
               else
               begin
                  s_next.sh = {1'b0, 1'b1, cmd_index, cmd_arg,
                     sdcf_pkg::crc7({2'b01, cmd_index, cmd_arg}),
                     1'b1};
                  s_next.cmd_out = 1'b0;
                  s_next.st = sdcf_pkg::ST_TX;
               end
            end
         end
         sdcf_pkg::ST_TX:
         begin
            if (rise)
               s_next.cnt = s_reg.cnt + 8'h01;
            if (fall)
            begin
               if (s_reg.cnt == sdcf_pkg::CMD_BITS)
               begin
                  s_next.cmd_oe = 1'b0;
                  s_next.cmd_out = sdcf_pkg::LINE_IDLE;
                  s_next.cnt = '0;
                  s_next.st = sdcf_pkg::ST_TURN;
               end
               else
               begin
                  s_next.sh = {s_reg.sh[46:0], 1'b1};
                  s_next.cmd_out = s_reg.sh[46];
               end
            end
         end
         sdcf_pkg::ST_TURN:
         begin
            if (rise)
               s_next.cnt = s_reg.cnt + 8'h01;
            if (fall && s_reg.cnt == sdcf_pkg::TURN_CLKS)
            begin
               s_next.cnt = '0;
               s_next.wcnt = '0;
               s_next.st = (s_reg.kind == sdcf_pkg::KIND_NONE) ?
                           sdcf_pkg::ST_IDLE : sdcf_pkg::ST_WAIT;
            end
         end
         sdcf_pkg::ST_WAIT:
         begin
            if (rise)
            begin
               if (!s_reg.sync2)
               begin
                  s_next.rx = {s_reg.rx[134:0], 1'b0};
                  s_next.cnt = 8'h01;
                  s_next.st = sdcf_pkg::ST_RECV;
               end
               else if (s_reg.wcnt == rsp_timeout)
               begin
                  s_next.tmo = 1'b1;
                  s_next.st = sdcf_pkg::ST_END;
               end
               else
                  s_next.wcnt = s_reg.wcnt + 16'h0001;
            end
         end
         sdcf_pkg::ST_RECV:
         begin
            if (rise)
            begin
               s_next.rx = {s_reg.rx[134:0], s_reg.sync2};
               s_next.cnt = s_reg.cnt + 8'h01;
               if (s_reg.cnt + 8'h01 == len)
                  s_next.st = sdcf_pkg::ST_END;
            end
         end
         sdcf_pkg::ST_INIT:
         begin
            if (rise)
               s_next.cnt = s_reg.cnt + 8'h01;
            if (fall && s_reg.cnt == sdcf_pkg::INIT_CLKS)
            begin
               s_next.cmd_oe = 1'b0;
               s_next.dat_oe = '0;
               s_next.st = sdcf_pkg::ST_IDLE;
            end
         end
         sdcf_pkg::ST_END:
         begin
            if (!s_reg.clk)
            begin
               s_next.clk = 1'b0;
               s_next.div = '0;
               s_next.rsp.frame = s_reg.rx;
               s_next.rsp.timeout = s_reg.tmo;
               s_next.rsp.index = short_rsp ?
                  s_reg.rx[sdcf_pkg::IDX_HI:sdcf_pkg::IDX_LO] :
                  s_reg.rx[133:128];
               s_next.rsp.arg = s_reg.rx[sdcf_pkg::ARG_HI:sdcf_pkg::ARG_LO];
               s_next.rsp.crc_err = !s_reg.tmo && short_rsp &&
                  (sdcf_pkg::crc7(s_reg.rx[sdcf_pkg::POS_START:8]) !=
                   s_reg.rx[sdcf_pkg::CRC_HI:sdcf_pkg::CRC_LO]);
               s_next.rsp.frm_err = !s_reg.tmo &&
                  (!s_reg.rx[0] ||
                   (short_rsp && s_reg.rx[sdcf_pkg::POS_DIR]));
               s_next.st = sdcf_pkg::ST_PUSH;
            end
         end
         sdcf_pkg::ST_PUSH:
         begin
            if (push_if.ready)
               s_next.st = sdcf_pkg::ST_IDLE;
         end
         default:
            s_next.st = sdcf_pkg::ST_IDLE;
      endcase
      s_next.cmd_ready = (s_next.st == sdcf_pkg::ST_IDLE);
   end

   // The data lines are only driven high during the wake-up clocks; block
   // transfers on them, any width and their 16-bit checksum belong to a
   // separate data engine, so here they are released outside that phase.
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         s_reg <= '0;
         s_reg.cmd_out <= sdcf_pkg::LINE_IDLE;
         s_reg.dat_out <= '1;
      end
      else
         s_reg <= s_next;
   end

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!resetn);

   idle_clk_low_a: assert property (
      s_reg.st inside {sdcf_pkg::ST_IDLE, sdcf_pkg::ST_PUSH} |-> !sd_clk)
      else $error("card clock high while bus idle");

   start_bit_a: assert property (
      $rose(sd_cmd_oe) && s_reg.st == sdcf_pkg::ST_TX |-> !sd_cmd_out)
      else $error("command frame did not open with zero");

   frame_len_a: assert property (
      (s_reg.st == sdcf_pkg::ST_TX) ##1 (s_reg.st == sdcf_pkg::ST_TURN)
      |-> $past(s_reg.cnt) == sdcf_pkg::CMD_BITS)
      else $error("command frame not 48 clocks long");

   out_on_fall_a: assert property (
      $past(s_reg.st == sdcf_pkg::ST_TX) && s_reg.st == sdcf_pkg::ST_TX &&
      $changed(sd_cmd_out) |-> $fell(sd_clk))
      else $error("command line changed off the falling edge");

   tx_crc_a: assert property (
      $rose(s_reg.st == sdcf_pkg::ST_TX) |-> s_reg.sh[46] && s_reg.sh[0] &&
      s_reg.sh[7:1] == sdcf_pkg::crc7(s_reg.sh[47:8]))
      else $error("outgoing frame checksum or marker bits wrong");

   turn_release_a: assert property (
      $rose(s_reg.st == sdcf_pkg::ST_TURN) |->
      (!sd_cmd_oe && sd_dat_oe == 8'h00)[*2])
      else $error("lines not released for turnaround");

   rx_crc_a: assert property (
      push_if.valid && s_reg.kind == sdcf_pkg::KIND_SHORT &&
      !s_reg.rsp.timeout |-> s_reg.rsp.crc_err ==
      (sdcf_pkg::crc7(s_reg.rsp.frame[47:8]) != s_reg.rsp.frame[7:1]))
      else $error("response checksum flag disagrees with frame");

   init_len_a: assert property (
      $fell(s_reg.st == sdcf_pkg::ST_INIT) |->
      $past(s_reg.cnt) == sdcf_pkg::INIT_CLKS && $past(sd_cmd_out) &&
      $past(sd_cmd_oe))
      else $error("wake-up clocks not 74 with line high");

   accept_a: assert property (
      $rose(sd_cmd_oe) |-> $past(cmd_valid && cmd_ready))
      else $error("command line driven without a request");

   timeout_a: assert property (
      $rose(s_reg.tmo) |-> $past(s_reg.wcnt) == rsp_timeout &&
      s_reg.st == sdcf_pkg::ST_END)
      else $error("response timeout at wrong count");

   short_c: cover property (push_if.valid && push_if.ready &&
      s_reg.kind == sdcf_pkg::KIND_SHORT && !s_reg.rsp.timeout);
   long_c: cover property (push_if.valid && push_if.ready &&
      s_reg.kind == sdcf_pkg::KIND_LONG);
   timeout_c: cover property ($rose(s_reg.tmo));
   init_c: cover property ($fell(s_reg.st == sdcf_pkg::ST_INIT));

endmodule
`default_nettype wire

// file: inc/sdcf_pkg.sv
/*
 Shared constants, types and the seven-bit frame checksum for the host-side
 memory-card command framer. Assumes a 250 MHz system clock.
*/
package sdcf_pkg;

   localparam int MCLK_KHZ = 32'h0003_D090;
   localparam int DS_KHZ   = 32'h0000_61A8;
   localparam int HS_KHZ   = 32'h0000_C350;
   localparam int ID_KHZ   = 32'h0000_0190;

   // Least half period of the card clock, rounded up to whole mclk cycles.
   localparam logic [9:0] HALF_DS =
      10'((MCLK_KHZ + 2 * DS_KHZ - 1) / (2 * DS_KHZ));
   localparam logic [9:0] HALF_HS =
      10'((MCLK_KHZ + 2 * HS_KHZ - 1) / (2 * HS_KHZ));
   localparam logic [9:0] HALF_ID =
      10'((MCLK_KHZ + 2 * ID_KHZ - 1) / (2 * ID_KHZ));

   localparam logic [7:0] CMD_BITS   = 8'h30;
   localparam logic [7:0] LONG_BITS  = 8'h88;
   localparam logic [7:0] TURN_CLKS  = 8'h02;
   localparam logic [7:0] INIT_CLKS  = 8'h4A;
   localparam logic [6:0] CRC7_POLY  = 7'h09;
   localparam logic       LINE_IDLE  = 1'h1;
   localparam logic [1:0] BUF_FULL   = 2'h2;

   localparam int POS_START = 47;
   localparam int POS_DIR   = 46;
   localparam int IDX_HI    = 45;
   localparam int IDX_LO    = 40;
   localparam int ARG_HI    = 39;
   localparam int ARG_LO    = 8;
   localparam int CRC_HI    = 7;
   localparam int CRC_LO    = 1;

   typedef enum logic [1:0] {KIND_NONE, KIND_SHORT, KIND_LONG, KIND_INIT}
      sdcf_kind_t;

   typedef enum logic [2:0] {ST_IDLE, ST_TX, ST_TURN, ST_WAIT, ST_RECV,
                             ST_INIT, ST_END, ST_PUSH} sdcf_state_t;

   typedef struct packed {
      logic         timeout;
      logic         crc_err;
      logic         frm_err;
      logic [5:0]   index;
      logic [31:0]  arg;
      logic [135:0] frame;
   } sdcf_rsp_t;

   // Checksum over the 40 leading bits of a short frame, zero seed.
   function automatic logic [6:0] crc7(input logic [39:0] d);
      logic [6:0] c;
      logic       fb;
      c = '0;
      for (int i = 39; i >= 0; i--)
      begin
         fb = c[6] ^ d[i];
         c = {c[5:0], 1'b0};
         if (fb)
            c = c ^ CRC7_POLY;
      end
      return c;
   endfunction

endpackage

// file: inc/sdcf_if.sv
/*
 Valid/ready carrier for received responses between the framer and its
 two-entry buffer. Assumes both ends share one clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface sdcf_if;
   logic                valid;
   logic                ready;
   sdcf_pkg::sdcf_rsp_t data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// file: rtl/sdcf_buf.sv
/*
 Two-entry response buffer with valid and ready on both sides.
 Assumes one clock and an asynchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module sdcf_buf (
   input  wire logic mclk,
   input  wire logic resetn,
   sdcf_if.snk       wr,
   sdcf_if.src       rd
);

   typedef struct packed {
      sdcf_pkg::sdcf_rsp_t head;
      sdcf_pkg::sdcf_rsp_t tail;
      logic [1:0]          cnt;
      logic                vld;
   } sdcf_buf_t;

   sdcf_buf_t s_reg;
   sdcf_buf_t s_next;
   logic      push;
   logic      pop;

   assign wr.ready = (s_reg.cnt != sdcf_pkg::BUF_FULL);
   assign rd.valid = s_reg.vld;
   assign rd.data  = s_reg.head;
   assign push     = wr.valid && wr.ready;
   assign pop      = rd.valid && rd.ready;

   // The head entry is a register of its own, so the read data leave a
   // flip-flop with no multiplexer behind it; a pop moves the tail forward.
   always_comb
   begin
      s_next = s_reg;
      if (pop)
         s_next.head = s_reg.tail;
      if (push && (s_reg.cnt == 2'h0 || (pop && s_reg.cnt == 2'h1)))
         s_next.head = wr.data;
      else if (push)
         s_next.tail = wr.data;
      s_next.cnt = 2'(s_reg.cnt + {1'b0, push} - {1'b0, pop});
      s_next.vld = (s_next.cnt != 2'h0);
   end

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
         s_reg <= '0;
      else
         s_reg <= s_next;
   end

endmodule
`default_nettype wire

// file: verification/sdcf_card_model.sv
/*
 Behavioural memory card on the far side of the host framer: captures
 command frames on the rising card clock and answers short or long
 responses, changing the line on falling edges.
 Assumes the bench resolves the command wire with a pull-up.
*/
`timescale 1ns/1ps
`default_nettype none
module sdcf_card_model (
   input  wire logic                 sd_clk,
   input  wire logic                 cmd_line,
   input  wire sdcf_pkg::sdcf_kind_t kind,
   input  wire logic [1:0]           mode,
   input  wire logic [7:0]           delay,
   output logic                      card_oe,
   output logic                      card_out,
   output logic [47:0]               last_cmd,
   output int                        rsp_count
);
   logic [135:0] r;
   logic [127:0] w;
   logic [47:0]  f;
   int           n;

   function automatic logic [6:0] crc7(input logic [39:0] d);
      logic [6:0] c;
      c = 7'h00;
      for (int i = 39; i >= 0; i--)
      begin
         c = {c[5:0], 1'b0} ^ (((c[6] ^ d[i]) == 1'b1) ? 7'h09 : 7'h00);
      end
      return c;
   endfunction

   // Mode 1 corrupts the short-response checksum, 2 clears the stop bit, 3 stays silent.
   initial
   begin
      card_oe = 1'b0;
      card_out = 1'b1;
      last_cmd = 48'h0000_0000_0000;
      rsp_count = 0;
      forever
      begin
         @(posedge sd_clk);
         if (cmd_line === 1'b0)
         begin
            f = 48'h0000_0000_0000;
            for (int i = 0; i < 48; i++)
            begin
               if (i != 0)
                  @(posedge sd_clk);
               f = {f[46:0], cmd_line};
            end
            last_cmd = f;
            if ((kind == sdcf_pkg::KIND_SHORT || kind == sdcf_pkg::KIND_LONG)
                && mode != 2'h3 && f[46] && f[0]
                && f[7:1] == crc7(f[47:8]))
            begin
               w = {4{f[39:8]}};
               r = {2'b00, 6'h3F, w[126:0], mode != 2'h2};
               n = 136;
               if (kind == sdcf_pkg::KIND_SHORT)
               begin
                  r[47:8] = {2'b00, f[45:40], f[39:8] ^ 32'h0000_0120};
                  r[7:1] = crc7(r[47:8]) ^ {6'h00, mode == 2'h1};
                  r[0] = (mode != 2'h2);
                  n = 48;
               end
               // Two whole clocks plus delay stay released before the start bit.
               repeat (8'h03 + delay) @(negedge sd_clk);
               card_oe = 1'b1;
               for (int i = n - 1; i >= 0; i--)
               begin
                  card_out = r[i];
                  @(negedge sd_clk);
               end
               card_oe = 1'b0;
               card_out = 1'b1;
               rsp_count++;
            end
         end
      end
   end
endmodule
`default_nettype wire

// file: verification/sdcf_host_tb_top.sv
/*
 Self-checking bench for the host command framer against a card model.
 Assumes the command wire has a pull-up and the bench drives all inputs
 one nanosecond after the rising system clock.
*/
`timescale 1ns/1ps
`default_nettype none
module sdcf_host_tb_top;
   typedef struct packed {
      logic [1:0]          k;
      sdcf_pkg::sdcf_rsp_t r;
   } sdcf_exp_t;

   logic                 mclk, resetn, cmd_valid, cmd_ready, hs_mode;
   logic                 id_mode, rsp_valid, rsp_ready, rsp_timed_out;
   logic                 rsp_crc_err, rsp_frm_err, sd_clk, sd_cmd_out;
   logic                 sd_cmd_oe, card_oe, card_out, hold;
   logic [5:0]           cmd_index, rsp_index;
   logic [31:0]          cmd_arg, rsp_arg, seed, rdy_seed;
   logic [9:0]           clk_half;
   logic [15:0]          rsp_timeout;
   logic [135:0]         rsp_frame;
   logic [7:0]           sd_dat_out, sd_dat_oe, card_delay;
   logic [1:0]           card_mode;
   logic [47:0]          last_cmd;
   sdcf_pkg::sdcf_kind_t cmd_kind, card_kind;
   sdcf_exp_t            exp_q[$];
   sdcf_exp_t            got_e;
   int                   miscompares, check_count, rsp_count, n0;
   int                   hi_run, hi_len, init_rises;
   wire                  cmd_line;

   `define CHK(a, b) \
      begin \
         check_count++; \
         if ((a) !== (b)) \
         begin \
            miscompares++; \
            $display("[FAIL] %0t got %0h exp %0h", $time, (a), (b)); \
         end \
      end

   // A clash between host and card drive shows up as an unknown line.
   assign cmd_line = (sd_cmd_oe & card_oe) ? 1'bx :
                     sd_cmd_oe ? sd_cmd_out : card_oe ? card_out : 1'b1;

   sdcf_host dut (.mclk(mclk), .resetn(resetn), .cmd_valid(cmd_valid),
      .cmd_ready(cmd_ready), .cmd_index(cmd_index), .cmd_arg(cmd_arg),
      .cmd_kind(cmd_kind), .clk_half(clk_half), .hs_mode(hs_mode),
      .id_mode(id_mode), .rsp_timeout(rsp_timeout), .rsp_valid(rsp_valid),
      .rsp_ready(rsp_ready), .rsp_index(rsp_index), .rsp_arg(rsp_arg),
      .rsp_frame(rsp_frame), .rsp_timed_out(rsp_timed_out),
      .rsp_crc_err(rsp_crc_err), .rsp_frm_err(rsp_frm_err), .sd_clk(sd_clk),
      .sd_cmd_in(cmd_line), .sd_cmd_out(sd_cmd_out), .sd_cmd_oe(sd_cmd_oe),
      .sd_dat_out(sd_dat_out), .sd_dat_oe(sd_dat_oe));

   sdcf_card_model card (.sd_clk(sd_clk), .cmd_line(cmd_line),
      .kind(card_kind), .mode(card_mode), .delay(card_delay),
      .card_oe(card_oe), .card_out(card_out), .last_cmd(last_cmd),
      .rsp_count(rsp_count));

   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic complete_run();
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // Sel 0 waits for cmd_ready, 1 for an empty queue, 2 for a new answer.
   task automatic wait_until(input int sel, input int ref_val);
      int n;
      n = 0;
      while (!((sel == 0 && cmd_ready === 1'b1) ||
               (sel == 1 && exp_q.size() == 0) ||
               (sel == 2 && rsp_count != ref_val)))
      begin
         @(posedge mclk);
         #1;
         n++;
         if (n > 32'h0001_0000)
         begin
            miscompares++;
            $display("[FAIL] %0t got %0h exp %0h", $time, sel, 0);
            complete_run();
         end
      end
   endtask

   task automatic send(input sdcf_pkg::sdcf_kind_t k, input logic [5:0] idx,
      input logic [31:0] arg, input logic [1:0] md, input logic [7:0] dl,
      input logic done);
      sdcf_exp_t    e;
      logic [39:0]  b;
      logic [127:0] w;
      card_kind = k;
      card_mode = md;
      card_delay = dl;
      e = '0;
      w = {4{arg}};
      b = {2'b00, idx, arg ^ 32'h0000_0120};
      if (md == 2'h3)
         e.k = 2'h2;
      else if (k == sdcf_pkg::KIND_LONG)
         e.k = 2'h1;
      e.r.timeout = (md == 2'h3);
      e.r.crc_err = (md == 2'h1);
      e.r.frm_err = (md == 2'h2);
      e.r.frame = {88'h0, b, card.crc7(b) ^ {6'h00, md == 2'h1}, md != 2'h2};
      if (e.k == 2'h1)
         e.r.frame = {2'b00, 6'h3F, w[126:0], md != 2'h2};
      e.r.index = (e.k == 2'h1) ? e.r.frame[133:128] : e.r.frame[45:40];
      e.r.arg = e.r.frame[39:8];
      if (k == sdcf_pkg::KIND_SHORT || k == sdcf_pkg::KIND_LONG)
         exp_q.push_back(e);
      cmd_index = idx;
      cmd_arg = arg;
      cmd_kind = k;
      cmd_valid = 1'b1;
      wait_until(0, 0);
      @(posedge mclk);
      #1;
      cmd_valid = 1'b0;
      if (done)
      begin
         repeat (2) @(posedge mclk);
         wait_until(0, 0);
         if (k != sdcf_pkg::KIND_INIT)
            `CHK(last_cmd, {2'b01, idx, arg, card.crc7({2'b01, idx, arg}), 1'b1});
         `CHK({sd_clk, sd_cmd_oe, sd_dat_oe}, 10'h000);
      end
   endtask

   task automatic floor_chk(input logic [9:0] h, input logic hs,
      input logic id, input int x);
      clk_half = h;
      hs_mode = hs;
      id_mode = id;
      send(sdcf_pkg::KIND_NONE, 6'h00, 32'h0000_0000, 2'h3, 8'h00, 1'b1);
      `CHK(hi_len, x);
      `CHK(rsp_valid, 1'b0);
   endtask

   initial
   begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end

   always @(posedge mclk)
   begin
      if (sd_clk === 1'b1)
         hi_run++;
      else if (hi_run != 0)
      begin
         hi_len = hi_run;
         hi_run = 0;
      end
      if (resetn === 1'b1 && rsp_valid === 1'b1 && rsp_ready === 1'b1)
      begin
         `CHK(exp_q.size() > 0, 1'b1);
         if (exp_q.size() > 0)
         begin
            got_e = exp_q.pop_front();
            `CHK(rsp_timed_out, got_e.r.timeout);
            if (got_e.k != 2'h2)
            begin
               `CHK(rsp_crc_err, got_e.r.crc_err);
               `CHK(rsp_frm_err, got_e.r.frm_err);
               `CHK({rsp_index, rsp_arg}, {got_e.r.index, got_e.r.arg});
               `CHK((got_e.k == 2'h1) ? rsp_frame : {88'h0, rsp_frame[47:0]}, got_e.r.frame);
            end
         end
      end
      #1;
      rsp_ready = hold ? 1'b0 : rdy_seed[0];
      rdy_seed = lfsr_next(rdy_seed);
   end

   always @(posedge sd_clk)
   begin
      if (sd_dat_oe === 8'hFF && sd_cmd_oe === 1'b1)
      begin
         init_rises++;
         `CHK({sd_cmd_out, sd_dat_out}, 9'h1FF);
      end
   end

   initial
   begin
      {resetn, cmd_valid, hs_mode, id_mode, hold, rsp_ready} = 6'h00;
      {miscompares, check_count, hi_run, hi_len, init_rises} = '0;
      cmd_index = 6'h00;
      cmd_arg = 32'h0000_0000;
      cmd_kind = sdcf_pkg::KIND_NONE;
      clk_half = 10'h008;
      rsp_timeout = 16'h0008;
      seed = 32'h0000_B740;
      rdy_seed = 32'h0000_B740;
      repeat (5) @(posedge mclk);
      #1;
      `CHK({sd_clk, sd_cmd_oe, sd_cmd_out, sd_dat_oe, sd_dat_out, cmd_ready, rsp_valid}, 21'h4_03FC);
      repeat (5) @(posedge mclk);
      #1;
      resetn = 1'b1;
      send(sdcf_pkg::KIND_INIT, 6'h00, 32'h0000_0000, 2'h3, 8'h00, 1'b1);
      `CHK(init_rises, 32'h0000_004A);
      send(sdcf_pkg::KIND_NONE, 6'h00, 32'h0000_0000, 2'h3, 8'h00, 1'b1);
      `CHK(last_cmd, 48'h4000_0000_0095);
      send(sdcf_pkg::KIND_SHORT, 6'h37, 32'h0000_0000, 2'h0, 8'h00, 1'b1);
      `CHK(last_cmd, 48'h7700_0000_0065);
      `CHK({card.crc7(40'h37_0000_0120), card.crc7(40'h03_B368_0500)}, 14'h208C);
      for (int i = 0; i < 6; i++)
      begin
         seed = lfsr_next(lfsr_next(seed));
         send(i[0] ? sdcf_pkg::KIND_LONG : sdcf_pkg::KIND_SHORT, seed[5:0],
              lfsr_next(seed), 2'h0, {5'h00, seed[10:8]}, 1'b1);
      end
      send(sdcf_pkg::KIND_SHORT, 6'h11, seed, 2'h0, 8'h08, 1'b1);
      send(sdcf_pkg::KIND_SHORT, 6'h12, seed, 2'h1, 8'h02, 1'b1);
      send(sdcf_pkg::KIND_SHORT, 6'h13, seed, 2'h2, 8'h01, 1'b1);
      send(sdcf_pkg::KIND_LONG, 6'h02, seed, 2'h2, 8'h00, 1'b1);
      send(sdcf_pkg::KIND_SHORT, 6'h29, seed, 2'h3, 8'h00, 1'b1);
      wait_until(1, 0);
      // Hold the consumer off so the two-entry buffer fills and stalls.
      hold = 1'b1;
      send(sdcf_pkg::KIND_SHORT, 6'h03, seed, 2'h0, 8'h00, 1'b1);
      send(sdcf_pkg::KIND_LONG, 6'h09, ~seed, 2'h0, 8'h03, 1'b1);
      n0 = rsp_count;
      send(sdcf_pkg::KIND_SHORT, 6'h07, seed ^ 32'h0000_FFFF, 2'h0, 8'h00, 1'b0);
      wait_until(2, n0);
      repeat (4) @(posedge mclk);
      #1;
      `CHK({cmd_ready, rsp_valid}, 2'h1);
      hold = 1'b0;
      wait_until(1, 0);
      wait_until(0, 0);
      floor_chk(10'h001, 1'b1, 1'b0, 32'h0000_0003);
      floor_chk(10'h001, 1'b0, 1'b0, 32'h0000_0005);
      floor_chk(10'h008, 1'b0, 1'b0, 32'h0000_0008);
      floor_chk(10'h001, 1'b1, 1'b1, 32'h0000_0139);
      complete_run();
   end
endmodule
`default_nettype wire
